//--- hpvol_pkg.sv
// shared constants for the headphone volume slew control block
`default_nettype none
package hpvol_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned ZC_TIMEOUT_MS = 100;
    localparam int unsigned ZC_TIMEOUT_CYC = CLK_HZ / 1000 * ZC_TIMEOUT_MS;
    localparam int unsigned SHORT_MS      = 100;
    localparam int unsigned SHORT_CYC     = CLK_HZ / 1000 * SHORT_MS;
    localparam int unsigned STEP_US       = 100;
    localparam int unsigned STEP_CYC      = CLK_HZ / 1000000 * STEP_US;

    localparam logic [5:0] GAIN_MUTE = 6'h00;
    localparam logic [5:0] GAIN_MAX  = 6'h3F;

    // register offsets (byte addresses, word aligned except REG_BIAS at byte 1 of the REG_MIC word)
    localparam logic [3:0] REG_VOLUME = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam logic [3:0] REG_MIC    = 4'h8;
    localparam logic [3:0] REG_BIAS   = 4'h9;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // ctrl fields
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_SLEW_N = 1;
    localparam int unsigned CTRL_ZC_N   = 2;
    localparam int unsigned CTRL_IRQ    = 3;
    localparam logic [2:0]  CTRL_RST    = 3'h0;
    localparam logic [2:0]  BIAS_RST    = 3'h0;

    typedef enum logic [3:0] {
        HP_OFF  = 4'b0001,
        HP_UP   = 4'b0010,
        HP_RUN  = 4'b0100,
        HP_DOWN = 4'b1000
    } hpvol_state_t;
endpackage
`default_nettype wire

//--- hpvol_ctrl.sv
// headphone volume slewing, short, rail and mic setting control
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`default_nettype none
module hpvol_ctrl #(
    parameter int unsigned ZC_CYC    = hpvol_pkg::ZC_TIMEOUT_CYC,
    parameter int unsigned SHORT_CY  = hpvol_pkg::SHORT_CYC,
    parameter int unsigned STEP_CY   = hpvol_pkg::STEP_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        zero_cross_in,
    input  wire logic        left_low_load,
    input  wire logic        right_low_load,
    input  wire logic        out_above_thresh,
    output logic [5:0]       gain_code,
    output logic             output_enable,
    output logic             left_enable,
    output logic             right_output_enable,
    output logic             high_rails,
    output logic             mic_gain_24db,
    output logic [2:0]       mic_bias_sel,
    output logic             irq_out,
    output logic             irq_oe_n
);
    localparam logic [31:0] ZC_LIM = 32'(ZC_CYC);
    localparam logic [31:0] SH_LIM = 32'(SHORT_CY);
    localparam logic [31:0] ST_LIM = 32'(STEP_CY);

    typedef struct packed {
        hpvol_pkg::hpvol_state_t st;
        logic [5:0]  target;
        logic [5:0]  gain;
        logic [2:0]  ctrl;
        logic        irq_req;
        logic        mic24;
        logic [2:0]  bias;
        logic [31:0] zc_cnt;
        logic [31:0] step_cnt;
        logic [31:0] sh_l;
        logic [31:0] sh_r;
        logic        short_l;
        logic        short_r;
        logic [1:0]  zc_sync;
        logic [1:0]  ll_sync;
        logic [1:0]  rl_sync;
        logic [1:0]  th_sync;
        logic        zc_prev;
        logic        rails;
        logic        ack;
        logic [31:0] rdata;
    } hpvol_regs_t;

    hpvol_regs_t s_q;
    hpvol_regs_t s_d;

    function automatic logic [5:0] step_toward(input logic [5:0] cur,
                                               input logic [5:0] tgt);
        if (cur < tgt) begin
            step_toward = cur + 6'h01;
        end else if (cur > tgt) begin
            step_toward = cur - 6'h01;
        end else begin
            step_toward = cur;
        end
    endfunction

    logic        zc_edge;
    logic        slew_on;
    logic        zc_on;
    logic        tick;
    logic        zc_tmo;
    logic        may_apply;
    logic        req;
    logic        wr_go;
    logic [5:0]  goal;

    always_comb begin
        s_d = s_q;
        req = (avs_read | avs_write) & ~s_q.ack;
        // writes land on the edge where waitrequest is seen low, not before
        wr_go = avs_write & s_q.ack;
        // pins pass two flops before use
        s_d.zc_sync = {s_q.zc_sync[0], zero_cross_in};
        s_d.ll_sync = {s_q.ll_sync[0], left_low_load};
        s_d.rl_sync = {s_q.rl_sync[0], right_low_load};
        s_d.th_sync = {s_q.th_sync[0], out_above_thresh};
        s_d.zc_prev = s_q.zc_sync[1];
        zc_edge = s_q.zc_sync[1] ^ s_q.zc_prev;
        slew_on = ~s_q.ctrl[hpvol_pkg::CTRL_SLEW_N];
        zc_on   = ~s_q.ctrl[hpvol_pkg::CTRL_ZC_N];
        // count-based timers on sys_clk only
        tick   = (s_q.step_cnt >= ST_LIM - 32'd1);
        zc_tmo = (s_q.zc_cnt >= ZC_LIM - 32'd1);
        s_d.step_cnt = tick ? 32'd0 : s_q.step_cnt + 32'd1;
        s_d.zc_cnt = zc_tmo ? s_q.zc_cnt : s_q.zc_cnt + 32'd1;
        s_d.rails = s_q.th_sync[1];
        // bus
        s_d.ack = req;
        s_d.rdata = 32'h0000_0000;
        if (wr_go && avs_byteenable[0]) begin
            if (avs_address == hpvol_pkg::REG_VOLUME) begin
                s_d.target = avs_writedata[5:0];
            end else if (avs_address == hpvol_pkg::REG_CTRL) begin
                s_d.ctrl = avs_writedata[2:0];
                s_d.irq_req = avs_writedata[hpvol_pkg::CTRL_IRQ];
            end else if (avs_address == hpvol_pkg::REG_MIC) begin
                s_d.mic24 = avs_writedata[0];
            end
        end
        if (wr_go && avs_byteenable[1] &&
            avs_address == hpvol_pkg::REG_MIC) begin
            s_d.bias = avs_writedata[10:8];
        end
        if (req && avs_read) begin
            if (avs_address == hpvol_pkg::REG_VOLUME) begin
                s_d.rdata = {26'h0, s_q.target};
            end else if (avs_address == hpvol_pkg::REG_CTRL) begin
                s_d.rdata = {28'h0, s_q.irq_req, s_q.ctrl};
            end else if (avs_address == hpvol_pkg::REG_MIC) begin
                s_d.rdata = {21'h0, s_q.bias, 7'h0, s_q.mic24};
            end else if (avs_address == hpvol_pkg::REG_STATUS) begin
                // odd order kept: gain[0] sits above gain[5:1]
                s_d.rdata = {18'h0,
                             s_q.st,
                             s_q.rails,
                             s_q.short_r,
                             s_q.short_l,
                             s_q.gain[0],
                             s_q.gain[5:1],
                             1'b0};
            end
        end
        // short persistence per channel
        if (s_q.ll_sync[1]) begin
            if (s_q.sh_l >= SH_LIM - 32'd1) begin
                s_d.short_l = 1'b1;
            end else begin
                s_d.sh_l = s_q.sh_l + 32'd1;
            end
        end else begin
            s_d.sh_l = 32'd0;
        end
        if (s_q.rl_sync[1]) begin
            if (s_q.sh_r >= SH_LIM - 32'd1) begin
                s_d.short_r = 1'b1;
            end else begin
                s_d.sh_r = s_q.sh_r + 32'd1;
            end
        end else begin
            s_d.sh_r = 32'd0;
        end
        if (~s_q.ctrl[hpvol_pkg::CTRL_EN]) begin
            s_d.short_l = 1'b0;
            s_d.short_r = 1'b0;
        end
        // gain sequencing
        goal = s_q.target;
        if (s_q.st != hpvol_pkg::HP_RUN && s_q.st != hpvol_pkg::HP_UP) begin
            goal = hpvol_pkg::GAIN_MUTE;
        end
        may_apply = zc_on ? (zc_edge | zc_tmo) : 1'b1;
        if (slew_on) begin
            may_apply = may_apply & (zc_on ? 1'b1 : tick);
        end
        case (s_q.st)
            hpvol_pkg::HP_OFF: begin
                s_d.gain = hpvol_pkg::GAIN_MUTE;
                if (s_q.ctrl[hpvol_pkg::CTRL_EN]) begin
                    s_d.st = slew_on ? hpvol_pkg::HP_UP : hpvol_pkg::HP_RUN;
                    s_d.zc_cnt = 32'd0;
                end
            end
            hpvol_pkg::HP_UP, hpvol_pkg::HP_RUN: begin
                if (~s_q.ctrl[hpvol_pkg::CTRL_EN]) begin
                    s_d.st = slew_on ? hpvol_pkg::HP_DOWN : hpvol_pkg::HP_OFF;
                end else begin
                    if (s_q.gain == goal) begin
                        s_d.st = hpvol_pkg::HP_RUN;
                    end else if (may_apply) begin
                        s_d.zc_cnt = 32'd0;
                        if (slew_on) begin
                            s_d.gain = step_toward(s_q.gain, goal);
                        end else begin
                            s_d.gain = goal;
                        end
                    end
                end
            end
            hpvol_pkg::HP_DOWN: begin
                if (s_q.gain == hpvol_pkg::GAIN_MUTE) begin
                    s_d.st = hpvol_pkg::HP_OFF;
                end else if (may_apply) begin
                    s_d.zc_cnt = 32'd0;
                    s_d.gain = step_toward(s_q.gain, hpvol_pkg::GAIN_MUTE);
                end
            end
            default: begin
                s_d.st = hpvol_pkg::HP_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // counters, syncs and flags all start at zero
            s_q <= '{st:      hpvol_pkg::HP_OFF,
                     target:  hpvol_pkg::GAIN_MUTE,
                     gain:    hpvol_pkg::GAIN_MUTE,
                     ctrl:    hpvol_pkg::CTRL_RST,
                     bias:    hpvol_pkg::BIAS_RST,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign gain_code = s_q.gain;
    assign output_enable = (s_q.st != hpvol_pkg::HP_OFF);
    assign left_enable = output_enable & ~s_q.short_l;
    assign right_output_enable = output_enable & ~s_q.short_r;
    assign high_rails = s_q.rails;
    assign mic_gain_24db = s_q.mic24;
    assign mic_bias_sel = s_q.bias;
    assign irq_out = 1'b0;
    assign irq_oe_n = ~s_q.irq_req;

    a_mute_at_on: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(output_enable) |-> gain_code == hpvol_pkg::GAIN_MUTE)
        else $error("gain not mute at output turn-on");
    a_single_step: assert property (@(posedge sys_clk) disable iff (srst)
        (~s_q.ctrl[hpvol_pkg::CTRL_SLEW_N] && output_enable &&
         $past(output_enable)) |->
        (gain_code == $past(gain_code) ||
         gain_code == $past(gain_code) + 6'h01 ||
         gain_code == $past(gain_code) - 6'h01))
        else $error("slew changed gain by more than one step");
    a_mute_at_off: assert property (@(posedge sys_clk) disable iff (srst)
        ($fell(output_enable) && $past(slew_on)) |->
        gain_code == hpvol_pkg::GAIN_MUTE)
        else $error("output disabled before mute");
    a_direct_jump: assert property (@(posedge sys_clk) disable iff (srst)
        (s_q.st == hpvol_pkg::HP_RUN && !slew_on && !zc_on &&
         s_q.ctrl[hpvol_pkg::CTRL_EN] && gain_code != s_q.target) |=>
        gain_code == $past(s_q.target))
        else $error("direct volume not applied next cycle");
    a_zc_gate: assert property (@(posedge sys_clk) disable iff (srst)
        (zc_on && !zc_edge && !zc_tmo && output_enable) |=>
        $stable(gain_code))
        else $error("gain changed without crossing or timeout");
    a_tmo_restart: assert property (@(posedge sys_clk) disable iff (srst)
        ($past(gain_code) != gain_code && $past(output_enable)) |->
        s_q.zc_cnt == 32'd0)
        else $error("timeout not restarted on gain change");
    a_short_one: assert property (@(posedge sys_clk) disable iff (srst)
        (s_q.short_l && !s_q.short_r && output_enable) |->
        (!left_enable && right_output_enable))
        else $error("short shut the wrong channel");
    a_rails_track: assert property (@(posedge sys_clk) disable iff (srst)
        $past(s_q.th_sync[1]) |-> high_rails)
        else $error("high rails not selected");
    a_short_time: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(s_q.short_l) |-> $past(s_q.sh_l) == SH_LIM - 32'd1)
        else $error("short flagged before persistence time");

    a_short_r_time: assert property (
        @(posedge sys_clk) disable iff (srst)
        $rose(s_q.short_r) |-> $past(s_q.sh_r) == SH_LIM - 32'h0000_0001)
        else $error("right short flagged before persistence time");

    a_short_two: assert property (
        @(posedge sys_clk) disable iff (srst)
        (s_q.short_r && !s_q.short_l && output_enable) |->
        (left_enable && !right_output_enable))
        else $error("right short shut the wrong channel");

    a_rails_low: assert property (
        @(posedge sys_clk) disable iff (srst)
        !$past(s_q.th_sync[1]) |-> !high_rails)
        else $error("high rails kept without level");

    // off state always parks the gain at mute
    a_off_mute: assert property (
        @(posedge sys_clk) disable iff (srst)
        s_q.st == hpvol_pkg::HP_OFF |=> gain_code == hpvol_pkg::GAIN_MUTE)
        else $error("gain not parked at mute while off");

    a_slew_pace: assert property (
        @(posedge sys_clk) disable iff (srst)
        (slew_on && !zc_on && !tick && output_enable) |=>
        $stable(gain_code))
        else $error("slew stepped between pace ticks");

    // pin is only ever pulled low, never driven high
    a_irq_drive: assert property (
        @(posedge sys_clk) disable iff (srst)
        !irq_oe_n |-> !irq_out)
        else $error("interrupt driven high");

    a_mic_gain: assert property (
        @(posedge sys_clk) disable iff (srst)
        (wr_go && avs_byteenable[0] && avs_address == hpvol_pkg::REG_MIC)
        |=> mic_gain_24db == $past(avs_writedata[0]))
        else $error("mic gain write lost");

    a_bias_lane: assert property (
        @(posedge sys_clk) disable iff (srst)
        (wr_go && avs_byteenable[1] && avs_address == hpvol_pkg::REG_MIC)
        |=> mic_bias_sel == $past(avs_writedata[10:8]))
        else $error("bias write lost");

    a_vol_target: assert property (
        @(posedge sys_clk) disable iff (srst)
        (wr_go && avs_byteenable[0] && avs_address == hpvol_pkg::REG_VOLUME)
        |=> s_q.target == $past(avs_writedata[5:0]))
        else $error("volume target not taken");

    // bus answers after exactly one wait state
    a_wait_first: assert property (@(posedge sys_clk) disable iff (srst)
        (avs_read || avs_write) && !$past(avs_read || avs_write) |->
        avs_waitrequest)
        else $error("first request cycle not stalled");

    a_wait_once: assert property (@(posedge sys_clk) disable iff (srst)
        avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
endmodule
`default_nettype wire

//--- hpvol_audio_model.sv
// analog front-end stand-in: crossings, load and level sense
`default_nettype none
module hpvol_audio_model (
    input  wire logic sys_clk,
    input  wire logic audio_on,
    input  wire logic short_l,
    input  wire logic short_r,
    input  wire logic loud,
    output var logic  zero_cross_in,
    output logic      left_low_load,
    output logic      right_low_load,
    output logic      out_above_thresh
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] ph = 3'h0;
    initial zero_cross_in = 1'b0;
    // silent audio never crosses, which leaves the timeout path open
    always @(posedge sys_clk) begin
        ph <= ph + 3'h1;
        if (audio_on && ph == 3'h6) zero_cross_in <= ~zero_cross_in;
    end
    assign left_low_load    = short_l;
    assign right_low_load   = short_r;
    assign out_above_thresh = loud;
endmodule
`default_nettype wire

//--- headphone_volume_slew_control_test.sv
// self-checking bench for the headphone volume slew control
`default_nettype none
module headphone_volume_slew_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, srst = 1'b1;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, zc, ll, rl, hi, oe, le, re, rails, mg, irq, irq_n;
    logic [5:0] gain_code, gp = 6'h00;
    logic [2:0] bias, b;
    logic audio_on = 1'b0, sh_l = 1'b0, sh_r = 1'b0, loud = 1'b0;
    logic step_chk = 1'b0, oe_p = 1'b0;
    logic [5:0] v1, t;
    int fails = 0, n_tests = 0, cyc = 0;
    hpvol_ctrl #(.ZC_CYC(50), .SHORT_CY(40), .STEP_CY(4)) i_dut (
        .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .zero_cross_in(zc), .left_low_load(ll), .right_low_load(rl),
        .out_above_thresh(hi), .gain_code(gain_code), .output_enable(oe),
        .left_enable(le), .right_output_enable(re), .high_rails(rails),
        .mic_gain_24db(mg), .mic_bias_sel(bias), .irq_out(irq),
        .irq_oe_n(irq_n));
    hpvol_audio_model i_audio (.sys_clk(sys_clk), .audio_on(audio_on),
        .short_l(sh_l), .short_r(sh_r), .loud(loud), .zero_cross_in(zc),
        .left_low_load(ll), .right_low_load(rl), .out_above_thresh(hi));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] mic_word(logic [2:0] s, logic g);
        return {21'h0, s, 7'h00, g};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d,
                       logic [3:0] be, output logic [31:0] r);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic ctl(logic [3:0] c);
        bus(1'b1, hpvol_pkg::REG_CTRL, {28'h0, c}, 4'hF, q);
    endtask
    task automatic vol(logic [5:0] v);
        bus(1'b1, hpvol_pkg::REG_VOLUME, {26'h0, v}, 4'hF, q);
    endtask
    task automatic wait_g(logic [5:0] g, int mx);
        for (int i = 0; i < mx && gain_code !== g; i++) @(negedge sys_clk);
    endtask
    always @(posedge sys_clk) begin
        gp <= gain_code;
        oe_p <= oe;
        if (step_chk && gain_code !== gp)
            chk("step", {31'h0, gain_code - gp == 6'h01 || gp - gain_code == 6'h01}, 1);
        if (step_chk && oe !== oe_p) chk("mute edge", gain_code, 0);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        void'($urandom(97));
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk("reset gain", gain_code, 0);
        chk("reset irq", irq_n, 1);
        bus(1'b0, hpvol_pkg::REG_STATUS, 32'h0, 4'hF, q);
        chk("status", q, 32'h400);
        $display("test reset done");
        b = 3'($urandom_range(7, 1));
        bus(1'b1, hpvol_pkg::REG_MIC, mic_word(b, 1'b1), 4'hF, q);
        chk("mic gain", mg, 1);
        chk("bias", bias, b);
        bus(1'b1, hpvol_pkg::REG_MIC, mic_word(~b, 1'b0), 4'h1, q);
        bus(1'b0, hpvol_pkg::REG_MIC, 32'h0, 4'hF, q);
        chk("mic word", q, mic_word(b, 1'b0));
        bus(1'b0, 4'h3, 32'h0, 4'hF, q);
        chk("unmapped", q, 0);
        ctl(4'h8);
        chk("irq drive", {irq_n, irq}, 0);
        ctl(4'h0);
        chk("irq free", irq_n, 1);
        $display("test registers done");
        ctl(4'h7);
        for (int i = 0; i < 3; i++) begin
            t = (i == 0) ? 6'($urandom_range(62, 1)) :
                (i == 1) ? 6'h3F : 6'h00;
            vol(t);
            @(negedge sys_clk);
            chk("jump", gain_code, t);
        end
        ctl(4'h6);
        $display("test direct done");
        step_chk = 1'b1;
        t = 6'($urandom_range(40, 10));
        vol(t);
        ctl(4'h5);
        wait_g(6'h03, 100);
        vol(6'h01);
        wait_g(6'h01, 100);
        chk("retarget", gain_code, 1);
        vol(t);
        wait_g(t, 400);
        chk("ramp up", gain_code, t);
        ctl(4'h4);
        wait_g(6'h00, 400);
        repeat (3) @(negedge sys_clk);
        chk("ramp off", oe, 0);
        audio_on = 1'b1;
        vol(6'h06);
        ctl(4'h1);
        wait_g(6'h06, 200);
        chk("zc steps", gain_code, 6);
        ctl(4'h0);
        wait_g(6'h00, 200);
        step_chk = 1'b0;
        audio_on = 1'b0;
        $display("test slew done");
        v1 = 6'($urandom_range(20, 1));
        vol(v1);
        ctl(4'h3);
        wait_g(v1, 80);
        vol(v1 + 6'd21);
        repeat (30) @(negedge sys_clk);
        chk("hold", gain_code, v1);
        wait_g(v1 + 6'd21, 40);
        chk("timeout", gain_code, v1 + 6'd21);
        audio_on = 1'b1;
        vol(v1 + 6'd42);
        wait_g(v1 + 6'd42, 16);
        chk("crossing", gain_code, v1 + 6'd42);
        audio_on = 1'b0;
        $display("test zero cross done");
        sh_l = 1'b1;
        repeat (30) @(negedge sys_clk);
        chk("brief low", le, 1);
        repeat (20) @(negedge sys_clk);
        chk("short", {le, re}, 2'b01);
        loud = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk("rails hi", rails, 1);
        loud = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("rails lo", rails, 0);
        $display("test analog done");
        test_done();
    end
endmodule
`default_nettype wire
